// file: verilog/pme_event_block.sv
// power-management event status register 2 and enable register 1
// assumes an 8-bit i/o port; neighbours supply the other enables

module pme_event_block import pme_pkg::*; #(
   parameter int unsigned HOLD_CYCLES = PME_HOLD_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [PME_ADDR_W-1:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   input wire logic button_in_i,
   input wire logic rtc_alarm_i,
   input wire logic resume_event_i,
   input wire logic sleep_request_i,
   input wire logic soft_off_request_i,
   input wire logic button_event_enable_i,
   input wire logic clock_alarm_enable_i,
   input wire logic button_override_enable_i,
   input wire logic control_interrupt_master_enable_i,
   input wire logic firmware_release_bit_i,
   input wire logic pm_counter_msb_i,
   input wire logic timer_status_clear_i,
   input wire logic global_status_clear_i,
   output logic timer_status_flag_o,
   output logic global_status_flag_o,
   output logic sci_o,
   output logic wake_event_o,
   output logic power_on_output_n_o,
   output logic power_on_oe_o
);
   logic [2:0] pins_sync;
   logic btn_prev;
   logic rtc_prev;
   logic msb_prev;
   logic hold_expired;
   logic button_status_flag;
   logic clock_alarm_status;
   logic button_override_status;
   logic wake_status_flag;
   logic timer_event_enable;
   logic global_event_enable;
   pme_state_t state;
   pme_state_t next_state;

   pme_sync #(
      .WIDTH(3)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .async_i({resume_event_i, rtc_alarm_i, button_in_i}),
      .sync_o(pins_sync)
   );

   wire btn_s = pins_sync[0];
   wire rtc_s = pins_sync[1];
   wire resume_s = pins_sync[2];

   pme_hold_timer #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_hold (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .level_i(btn_s),
      .expired_o(hold_expired)
   );

   // register decode
   wire sel_sts2 = (io_addr_i == PME_OFS_STS2);
   wire sel_en1 = (io_addr_i == PME_OFS_EN1);
   wire wr_sts2 = io_wr_i && sel_sts2;
   wire wr_en1 = io_wr_i && sel_en1;
   wire clr_btn = wr_sts2 && io_wdata_i[PME_B_BTN];
   wire clr_rtc = wr_sts2 && io_wdata_i[PME_B_RTC];
   wire clr_ovr = wr_sts2 && io_wdata_i[PME_B_OVR];
   wire clr_wak_req = wr_sts2 && io_wdata_i[PME_B_WAK];

   // event detection
   wire btn_rise = btn_s && !btn_prev;
   wire rtc_rise = rtc_s && !rtc_prev;
   wire msb_change = (pm_counter_msb_i != msb_prev);
   wire override_fire = hold_expired && button_override_enable_i;

   // power state view
   wire in_working = (state == PME_ST_ON);
   wire in_sleep = (state == PME_ST_SLEEP);
   wire in_off = (state == PME_ST_OFF);
   wire button_wake = button_event_enable_i && button_status_flag;
   // override wins over a resume in the same cycle
   wire resume_now = (in_sleep || in_off) && !override_fire &&
                     (resume_s || button_wake);

   // interrupt sources
   wire src_btn = in_working && button_wake;
   wire src_rtc = clock_alarm_enable_i && clock_alarm_status;
   wire src_tmr = timer_event_enable && timer_status_flag_o;
   wire src_gbl = global_event_enable && global_status_flag_o;
   wire next_sci = control_interrupt_master_enable_i &&
                   (src_btn || src_rtc || src_tmr || src_gbl);

   wire [7:0] sts2_view = {wake_status_flag, 3'h0, button_override_status,
                           clock_alarm_status, 1'b0, button_status_flag};
   wire [7:0] en1_view = {2'h0, global_event_enable, 4'h0,
                          timer_event_enable};
   wire [7:0] next_rdata = sel_sts2 ? sts2_view :
                           sel_en1 ? en1_view : PME_RST_BYTE;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         btn_prev <= 1'b0;
         rtc_prev <= 1'b0;
         msb_prev <= 1'b0;
      end else begin
         btn_prev <= btn_s;
         rtc_prev <= rtc_s;
         msb_prev <= pm_counter_msb_i;
      end
   end

   // press sets flag regardless of enable
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         button_status_flag <= 1'b0;
      end else if (override_fire) begin
         button_status_flag <= 1'b0;
      end else if (btn_rise) begin
         button_status_flag <= 1'b1;
      end else if (clr_btn) begin
         button_status_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clock_alarm_status <= 1'b0;
      end else if (rtc_rise) begin
         clock_alarm_status <= 1'b1;
      end else if (clr_rtc) begin
         clock_alarm_status <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         button_override_status <= 1'b0;
      end else if (override_fire) begin
         button_override_status <= 1'b1;
      end else if (clr_ovr) begin
         button_override_status <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_status_flag <= 1'b0;
      end else if (resume_now) begin
         wake_status_flag <= 1'b1;
      end else if (clr_wak_req && !in_off) begin
         wake_status_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_status_flag_o <= 1'b0;
      end else if (msb_change) begin
         timer_status_flag_o <= 1'b1;
      end else if (timer_status_clear_i) begin
         timer_status_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         global_status_flag_o <= 1'b0;
      end else if (firmware_release_bit_i) begin
         global_status_flag_o <= 1'b1;
      end else if (global_status_clear_i) begin
         global_status_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_event_enable <= PME_RST_BYTE[PME_B_TIMER_EVENT_ENABLE];
         global_event_enable <= PME_RST_BYTE[PME_B_GLOBAL_EVENT_ENABLE];
      end else if (wr_en1) begin
         timer_event_enable <= io_wdata_i[PME_B_TIMER_EVENT_ENABLE];
         global_event_enable <= io_wdata_i[PME_B_GLOBAL_EVENT_ENABLE];
      end
   end

   // power state machine
   always_comb begin
      next_state = state;
      unique case (state)
         PME_ST_ON: begin
            if (override_fire || soft_off_request_i) begin
               next_state = PME_ST_OFF;
            end else if (sleep_request_i) begin
               next_state = PME_ST_SLEEP;
            end
         end
         PME_ST_SLEEP: begin
            if (override_fire || soft_off_request_i) begin
               next_state = PME_ST_OFF;
            end else if (resume_now) begin
               next_state = PME_ST_ON;
            end
         end
         PME_ST_OFF: begin
            if (resume_now) begin
               next_state = PME_ST_ON;
            end
         end
         default: begin
            next_state = PME_ST_ON;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= PME_ST_ON;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         power_on_output_n_o <= 1'b0;
         power_on_oe_o <= 1'b1;
      end else begin
         power_on_output_n_o <= in_off;
         power_on_oe_o <= !in_off;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sci_o <= 1'b0;
      end else begin
         sci_o <= next_sci;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_event_o <= 1'b0;
      end else begin
         wake_event_o <= in_sleep && button_wake;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         io_rdata_o <= PME_RST_BYTE;
      end else if (io_rd_i) begin
         io_rdata_o <= next_rdata;
      end
   end

   property p_btn_set;
      @(posedge mclk_i) disable iff (!rst_b_i)
      btn_rise && !override_fire |=> button_status_flag;
   endproperty
   a_btn_set: assert property (p_btn_set)
      else $error("button press did not set flag");

   property p_btn_sci;
      @(posedge mclk_i) disable iff (!rst_b_i)
      control_interrupt_master_enable_i && in_working &&
      button_event_enable_i && button_status_flag |=> sci_o;
   endproperty
   a_btn_sci: assert property (p_btn_sci)
      else $error("enabled button flag gave no interrupt");

   property p_sleep_wake;
      @(posedge mclk_i) disable iff (!rst_b_i)
      in_sleep && button_wake && !override_fire && !soft_off_request_i
      |=> wake_event_o && state == PME_ST_ON;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("sleeping button did not wake");

   property p_w1c;
      @(posedge mclk_i) disable iff (!rst_b_i)
      clr_rtc && !rtc_rise |=> !clock_alarm_status;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear alarm flag");

   property p_w0_keep;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sts2 && !io_wdata_i[PME_B_OVR] && button_override_status
      |=> button_override_status;
   endproperty
   a_w0_keep: assert property (p_w0_keep)
      else $error("write zero changed override flag");

   property p_override;
      @(posedge mclk_i) disable iff (!rst_b_i)
      override_fire |=> button_override_status && !button_status_flag
      && in_off ##1 !power_on_oe_o;
   endproperty
   a_override: assert property (p_override)
      else $error("override did not reach soft-off");

   property p_ovr_flags;
      @(posedge mclk_i) disable iff (!rst_b_i)
      $rose(button_override_status) |-> !button_status_flag;
   endproperty
   a_ovr_flags: assert property (p_ovr_flags)
      else $error("override left button flag set");

   property p_rtc_set;
      @(posedge mclk_i) disable iff (!rst_b_i)
      $rose(rtc_s) |=> clock_alarm_status;
   endproperty
   a_rtc_set: assert property (p_rtc_set)
      else $error("alarm did not set flag");

   property p_rtc_sci;
      @(posedge mclk_i) disable iff (!rst_b_i)
      control_interrupt_master_enable_i && clock_alarm_enable_i &&
      clock_alarm_status |=> sci_o;
   endproperty
   a_rtc_sci: assert property (p_rtc_sci)
      else $error("enabled alarm gave no interrupt");

   property p_wak_set;
      @(posedge mclk_i) disable iff (!rst_b_i)
      in_off ##1 state == PME_ST_ON |-> wake_status_flag;
   endproperty
   a_wak_set: assert property (p_wak_set)
      else $error("resume from off did not set wake flag");

   property p_wak_off_keep;
      @(posedge mclk_i) disable iff (!rst_b_i)
      in_off && wake_status_flag |=> wake_status_flag;
   endproperty
   a_wak_off_keep: assert property (p_wak_off_keep)
      else $error("wake flag cleared while powered off");

   property p_reserved;
      @(posedge mclk_i) disable iff (!rst_b_i)
      io_rd_i && sel_en1 |=> io_rdata_o[4:1] == 4'h0 &&
      io_rdata_o[7:6] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved enable bits read nonzero");

   property p_tmr_gate;
      @(posedge mclk_i) disable iff (!rst_b_i)
      timer_status_flag_o && !timer_event_enable && !src_btn &&
      !src_rtc && !src_gbl |=> !sci_o;
   endproperty
   a_tmr_gate: assert property (p_tmr_gate)
      else $error("disabled timer flag raised interrupt");

   property p_gbl_sci;
      @(posedge mclk_i) disable iff (!rst_b_i)
      control_interrupt_master_enable_i && src_gbl |=> sci_o;
   endproperty
   a_gbl_sci: assert property (p_gbl_sci)
      else $error("global enable and flag gave no interrupt");

   property p_msb;
      @(posedge mclk_i) disable iff (!rst_b_i)
      msb_change |=> timer_status_flag_o;
   endproperty
   a_msb: assert property (p_msb)
      else $error("counter msb change did not set timer flag");

   property p_master;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !control_interrupt_master_enable_i |=> !sci_o;
   endproperty
   a_master: assert property (p_master)
      else $error("interrupt raised with master enable off");
endmodule

// file: verilog/pme_pkg.sv
// constants for the power-management event status/enable block
// assumes an 8-bit system i/o register port, offsets within the block
package pme_pkg;
   localparam int unsigned PME_ADDR_W = 4;
   localparam logic [3:0] PME_OFS_STS2 = 4'h1;
   localparam logic [3:0] PME_OFS_EN1 = 4'h2;
   localparam logic [7:0] PME_RST_BYTE = 8'h00;
   // second status register fields
   localparam int unsigned PME_B_BTN = 0;
   localparam int unsigned PME_B_RTC = 2;
   localparam int unsigned PME_B_OVR = 3;
   localparam int unsigned PME_B_WAK = 7;
   // first enable register fields
   localparam int unsigned PME_B_TIMER_EVENT_ENABLE = 0;
   localparam int unsigned PME_B_GLOBAL_EVENT_ENABLE = 5;
   // button override hold time
   localparam int unsigned PME_HOLD_S = 4;
   localparam int unsigned PME_CLK_HZ = 100_000_000;
   localparam int unsigned PME_HOLD_CYCLES = PME_HOLD_S * PME_CLK_HZ;
   // system power state, gray along on -> sleep -> off
   typedef enum logic [1:0] {
      PME_ST_ON = 2'h0,
      PME_ST_SLEEP = 2'h1,
      PME_ST_OFF = 2'h3
   } pme_state_t;
endpackage

// file: verilog/pme_sync.sv
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from outside the clock domain
module pme_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// file: verilog/pme_hold_timer.sv
// hold timer: pulses once when a level has stayed high past a limit
// assumes level_i is already synchronised to mclk_i
module pme_hold_timer #(
   parameter int unsigned HOLD_CYCLES = 400_000_000,
   parameter int unsigned CNT_W = $clog2(HOLD_CYCLES + 2)
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic level_i,
   output logic expired_o
);
   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(HOLD_CYCLES);
   logic [CNT_W-1:0] count;
   wire at_limit = (count == LIMIT);

   // counts each clock while held until one past LIMIT, then stops; restarts on release
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count <= '0;
      end else if (!level_i) begin
         count <= '0;
      end else if (count <= LIMIT) begin
         count <= count + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         expired_o <= 1'b0;
      end else begin
         expired_o <= level_i && at_limit;
      end
   end
endmodule

// file: testbench/pme_event_block_tb.sv
// self-checking bench for the power-management event block
// assumes pme_pkg is compiled first; hold time shortened by parameter
module testbench import pme_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned HOLD = 20;
   localparam int LIMIT = 3000;
   localparam logic [3:0] OFS_NONE = 4'h5;
   localparam logic [7:0] K_PON = 8'h01;
   localparam logic [7:0] K_OFF_N = 8'h02;
   localparam logic [7:0] K_SCI = 8'h04;
   localparam logic [7:0] K_GBL = 8'h08;
   localparam logic [7:0] K_TMR = 8'h10;
   localparam logic [7:0] K_WAKE = 8'h20;
   localparam logic [7:0] S_BTN = 8'(1 << PME_B_BTN);
   localparam logic [7:0] S_RTC = 8'(1 << PME_B_RTC);
   localparam logic [7:0] S_OVR = 8'(1 << PME_B_OVR);
   localparam logic [7:0] S_WAK = 8'(1 << PME_B_WAK);
   localparam logic [7:0] E_TMR = 8'(1 << PME_B_TIMER_EVENT_ENABLE);
   localparam logic [7:0] E_GBL = 8'(1 << PME_B_GLOBAL_EVENT_ENABLE);

   typedef struct packed {
      logic [7:0] msk;
      logic [7:0] val;
      logic kind;
   } pme_tb_note_t;

   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [PME_ADDR_W-1:0] io_addr_i = '0;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   logic [7:0] io_rdata_o;
   logic button_in_i = 1'b0;
   logic rtc_alarm_i = 1'b0;
   logic resume_event_i = 1'b0;
   logic sleep_request_i = 1'b0;
   logic soft_off_request_i = 1'b0;
   logic button_event_enable_i = 1'b0;
   logic clock_alarm_enable_i = 1'b0;
   logic button_override_enable_i = 1'b0;
   logic control_interrupt_master_enable_i = 1'b0;
   logic firmware_release_bit_i = 1'b0;
   logic pm_counter_msb_i = 1'b0;
   logic timer_status_clear_i = 1'b0;
   logic global_status_clear_i = 1'b0;
   logic timer_status_flag_o;
   logic global_status_flag_o;
   logic sci_o;
   logic wake_event_o;
   logic power_on_output_n_o;
   logic power_on_oe_o;

   pme_tb_note_t notes[$];
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   logic rd_seen = 1'b0;
   logic probe_q = 1'b0;
   logic saw_wake = 1'b0;
   logic [7:0] obs;
   logic [7:0] v;

   assign obs = {2'b00, saw_wake, timer_status_flag_o, global_status_flag_o,
                 sci_o, power_on_output_n_o, power_on_oe_o};

   pme_event_block #(.HOLD_CYCLES(HOLD)) dut_u (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .button_in_i(button_in_i),
      .rtc_alarm_i(rtc_alarm_i), .resume_event_i(resume_event_i),
      .sleep_request_i(sleep_request_i),
      .soft_off_request_i(soft_off_request_i),
      .button_event_enable_i(button_event_enable_i),
      .clock_alarm_enable_i(clock_alarm_enable_i),
      .button_override_enable_i(button_override_enable_i),
      .control_interrupt_master_enable_i(control_interrupt_master_enable_i),
      .firmware_release_bit_i(firmware_release_bit_i),
      .pm_counter_msb_i(pm_counter_msb_i),
      .timer_status_clear_i(timer_status_clear_i),
      .global_status_clear_i(global_status_clear_i),
      .timer_status_flag_o(timer_status_flag_o),
      .global_status_flag_o(global_status_flag_o),
      .sci_o(sci_o), .wake_event_o(wake_event_o),
      .power_on_output_n_o(power_on_output_n_o),
      .power_on_oe_o(power_on_oe_o)
   );

   always #5 mclk_i = ~mclk_i;

   task automatic wrap_up;
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      tick();
      io_wr_i = 1'b0;
      tick();
   endtask

   // read data is compared by the monitor one edge after the read edge
   task automatic rd(input logic [3:0] a, input logic [7:0] d);
      notes.push_back('{msk: 8'hff, val: d, kind: 1'b0});
      io_addr_i = a;
      io_rd_i = 1'b1;
      tick();
      io_rd_i = 1'b0;
      tick();
   endtask

   task automatic probe(input logic [7:0] m, input logic [7:0] d);
      notes.push_back('{msk: m, val: d, kind: 1'b1});
      probe_q = 1'b1;
      tick();
      probe_q = 1'b0;
      tick();
   endtask

   always @(posedge mclk_i) begin : mon_b
      pme_tb_note_t e;
      logic [7:0] got;
      rd_seen <= io_rd_i;
      if (wake_event_o === 1'b1) begin
         saw_wake <= 1'b1;
      end
      if (rd_seen || probe_q) begin
         e = notes.pop_front();
         got = e.kind ? (obs & e.msk) : io_rdata_o;
         n_compared++;
         if (got !== e.val) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, e.val);
         end
      end
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32322));
      repeat (12) @(posedge mclk_i);
      #1;
      rst_b_i = 1'b1;
      rd(PME_OFS_STS2, PME_RST_BYTE);
      rd(PME_OFS_EN1, PME_RST_BYTE);
      probe(K_PON | K_OFF_N | K_SCI, K_PON);
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom());
         wr(PME_OFS_EN1, v);
         rd(PME_OFS_EN1, v & (E_TMR | E_GBL));
      end
      wr(OFS_NONE, 8'hff);
      rd(OFS_NONE, 8'h00);
      wr(PME_OFS_EN1, 8'h00);
      rd(PME_OFS_EN1, 8'h00);
      control_interrupt_master_enable_i = 1'b1;
      button_in_i = 1'b1;
      tick(2);
      button_in_i = 1'b0;
      tick(5);
      rd(PME_OFS_STS2, S_BTN);
      probe(K_SCI, 8'h00);
      button_event_enable_i = 1'b1;
      tick(3);
      probe(K_SCI, K_SCI);
      control_interrupt_master_enable_i = 1'b0;
      tick(3);
      probe(K_SCI, 8'h00);
      control_interrupt_master_enable_i = 1'b1;
      wr(PME_OFS_STS2, 8'h7e);
      rd(PME_OFS_STS2, S_BTN);
      wr(PME_OFS_STS2, S_BTN);
      rd(PME_OFS_STS2, 8'h00);
      probe(K_SCI, 8'h00);
      button_event_enable_i = 1'b0;
      tick($urandom_range(3, 1));
      rtc_alarm_i = 1'b1;
      tick(5);
      rd(PME_OFS_STS2, S_RTC);
      probe(K_SCI, 8'h00);
      clock_alarm_enable_i = 1'b1;
      tick(3);
      probe(K_SCI, K_SCI);
      rtc_alarm_i = 1'b0;
      wr(PME_OFS_STS2, S_RTC);
      rd(PME_OFS_STS2, 8'h00);
      clock_alarm_enable_i = 1'b0;
      wr(PME_OFS_EN1, E_TMR);
      pm_counter_msb_i = 1'b1;
      tick(3);
      probe(K_TMR | K_SCI, K_TMR | K_SCI);
      timer_status_clear_i = 1'b1;
      tick();
      timer_status_clear_i = 1'b0;
      tick(2);
      probe(K_TMR | K_SCI, 8'h00);
      wr(PME_OFS_EN1, 8'h00);
      pm_counter_msb_i = 1'b0;
      tick(3);
      probe(K_TMR | K_SCI, K_TMR);
      timer_status_clear_i = 1'b1;
      wr(PME_OFS_EN1, E_GBL);
      timer_status_clear_i = 1'b0;
      firmware_release_bit_i = 1'b1;
      tick();
      firmware_release_bit_i = 1'b0;
      tick(3);
      probe(K_GBL | K_SCI | K_TMR, K_GBL | K_SCI);
      global_status_clear_i = 1'b1;
      tick();
      global_status_clear_i = 1'b0;
      tick(2);
      probe(K_GBL | K_SCI, 8'h00);
      wr(PME_OFS_EN1, 8'h00);
      sleep_request_i = 1'b1;
      tick();
      sleep_request_i = 1'b0;
      button_event_enable_i = 1'b1;
      button_in_i = 1'b1;
      tick(2);
      button_in_i = 1'b0;
      tick(6);
      probe(K_WAKE | K_PON, K_WAKE | K_PON);
      rd(PME_OFS_STS2, S_BTN | S_WAK);
      button_event_enable_i = 1'b0;
      wr(PME_OFS_STS2, S_BTN);
      rd(PME_OFS_STS2, S_WAK);
      button_override_enable_i = 1'b1;
      button_in_i = 1'b1;
      tick(HOLD + 12);
      probe(K_PON | K_OFF_N, K_OFF_N);
      rd(PME_OFS_STS2, S_OVR | S_WAK);
      wr(PME_OFS_STS2, S_WAK);
      rd(PME_OFS_STS2, S_OVR | S_WAK);
      button_in_i = 1'b0;
      resume_event_i = 1'b1;
      tick(2);
      resume_event_i = 1'b0;
      tick(6);
      probe(K_PON | K_OFF_N, K_PON);
      wr(PME_OFS_STS2, S_WAK | S_OVR);
      rd(PME_OFS_STS2, 8'h00);
      soft_off_request_i = 1'b1;
      tick();
      soft_off_request_i = 1'b0;
      tick(3);
      probe(K_PON, 8'h00);
      resume_event_i = 1'b1;
      tick(2);
      resume_event_i = 1'b0;
      tick(6);
      probe(K_PON | K_OFF_N, K_PON);
      rd(PME_OFS_STS2, S_WAK);
      wr(PME_OFS_STS2, 8'hff);
      rd(PME_OFS_STS2, 8'h00);
      // mid-run power-on reset clears flags and enables
      wr(PME_OFS_EN1, E_TMR | E_GBL);
      button_in_i = 1'b1;
      tick(5);
      rst_b_i = 1'b0;
      tick(2);
      rst_b_i = 1'b1;
      button_in_i = 1'b0;
      rd(PME_OFS_EN1, 8'h00);
      rd(PME_OFS_STS2, 8'h00);
      wrap_up();
   end
endmodule
